// file: core/srom_cond_sel.v
// condition selector: picks one service or status condition by code
// assumes condition vectors are synchronous to the mapper clock
`include "srom_defs.vh"

module srom_cond_sel (
  input  wire [`SROM_CODE_W-1:0] code_i,
  input  wire [`SROM_SVC_W-1:0]  service_i,
  input  wire [`SROM_STAT_W-1:0] status_i,
  output reg                     cond_o
);
  wire [`SROM_CODE_W-1:0] sidx;
  assign sidx = code_i - `SROM_STAT_BASE;

  always @* begin
    cond_o = 1'b0;
    if ((code_i >= `SROM_STAT_BASE) && (sidx < `SROM_STAT_W)) begin
      cond_o = status_i[sidx[3:0]];                                 // see RQ10
    end else if ((code_i >= `SROM_SVC_SAMPLE_PRESSURE_FAULT) &&
                 (code_i <= `SROM_SVC_CALIBRATION_ALARM) &&
                 (code_i != `SROM_SVC_SPARE_OFF) &&
                 (code_i != `SROM_SVC_UNUSED)) begin
      cond_o = service_i[code_i[4:0]];                   // see RQ6 see RQ7 see RQ8 see RQ9
    end
  end
endmodule // srom_cond_sel

// file: core/srom_relay_chan.v
// one relay channel: hold or follow behaviour and an assert pulse
// assumes clear is a one-cycle pulse and armed a level, both on the same clock
module srom_relay_chan (
  input  wire clk_i,
  input  wire rst_i,
  input  wire cond_i,
  input  wire hold_i,
  input  wire armed_i,
  input  wire clear_i,
  output reg  relay_o,
  output reg  rise_o
);
  reg relay_nxt;

  always @* begin
    // a clear never masks a condition that is still present
    relay_nxt = cond_i | (hold_i & armed_i & relay_o & ~clear_i);   // see RQ3 see RQ5
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      relay_o <= 1'b0;                                              // see RQ11
      rise_o  <= 1'b0;
    end else begin
      relay_o <= relay_nxt;
      rise_o  <= relay_nxt & ~relay_o;
    end
  end
endmodule // srom_relay_chan

// file: core/srom_top.v
// status relay output mapper: fifteen relay outputs, each mapped to one
// selected condition, with hold or follow behaviour, behind a wishbone slave
// assumes condition inputs come from logic on clk_i; one clock, sync reset
//
// Notes on behaviour
// RQ1 - fifteen independent programmable isolated relay outputs
// RQ2 - each output has condition code and mode
// RQ3 - hold mode keeps output until manual clear
// RQ4 - after clear, latching off until re-arm
// RQ5 - follow mode drops output when condition ends
// RQ6 - codes one to nine select temperature/pressure faults
// RQ7 - codes ten to fourteen: coils, overflows, underflow
// RQ8 - codes fifteen to eighteen: range uncalibrated
// RQ9 - codes nineteen to twenty-six: remaining service conditions
// RQ10 - status group reports operating state and range
// RQ11 - unassigned codes stay off; reset unassigns all
//
// Decided for this implementation: register access over Wishbone and the address map.
`include "srom_defs.vh"

module srom_top #(
  parameter NUM_OUT = `SROM_NUM_OUT
) (
  input  wire                    clk_i,
  input  wire                    rst_i,
  // wishbone classic slave
  input  wire                    wb_cyc_i,
  input  wire                    wb_stb_i,
  input  wire                    wb_we_i,
  input  wire [7:0]              wb_adr_i,
  input  wire [3:0]              wb_sel_i,
  input  wire [31:0]             wb_dat_i,
  output reg  [31:0]             wb_dat_o,
  output reg                     wb_ack_o,
  // detected conditions, indexed by code
  input  wire [`SROM_SVC_W-1:0]  service_cond_i,
  input  wire [`SROM_STAT_W-1:0] status_cond_i,
  // relay drive and interrupt
  output wire [NUM_OUT-1:0]      relay_o,
  output reg                     irq_o
);

  // ****************************************
  // storage
  // ****************************************
  reg  [`SROM_CODE_W:0]   cfg_r [0:NUM_OUT-1];
  reg                     armed_r;
  reg  [NUM_OUT-1:0]      clear_r;
  reg  [`SROM_INT_W-1:0]  int_stat_r;
  reg  [`SROM_INT_W-1:0]  int_stat_nxt;
  reg  [`SROM_INT_W-1:0]  int_mask_r;
  reg  [31:0]             rd_nxt;
  reg                     disarm_ev_r;

  wire [NUM_OUT-1:0]      cond_w;
  wire [NUM_OUT-1:0]      rise_w;
  wire [15:0]             wmask;
  wire                    req;
  wire                    wr;
  wire                    rd;
  wire                    cfg_hit;
  wire [3:0]              cfg_idx;
  integer                 k;

  assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr      = req & wb_we_i;
  assign rd      = req & ~wb_we_i;
  assign wmask   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign cfg_hit = (wb_adr_i[7:6] == `SROM_ADR_CFG_BASE) && (wb_adr_i[5:2] < NUM_OUT);
  assign cfg_idx = wb_adr_i[5:2];

  // ****************************************
  // bus acknowledge
  // ****************************************
  // one wait-free answer: ack rises the cycle after the request is seen
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= rd ? rd_nxt : 32'h00000000;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  always @* begin
    rd_nxt = 32'h00000000;
    if (cfg_hit) begin
      rd_nxt[`SROM_CODE_W-1:0] = cfg_r[cfg_idx][`SROM_CODE_W-1:0];
      rd_nxt[`SROM_CFG_HOLD]   = cfg_r[cfg_idx][`SROM_CODE_W];
    end else begin
      case (wb_adr_i)
        `SROM_ADR_CTRL: begin
          rd_nxt[`SROM_CTRL_REARM] = armed_r;
        end
        `SROM_ADR_RELAY: begin
          rd_nxt[NUM_OUT-1:0] = relay_o;
        end
        `SROM_ADR_SERVICE: begin
          rd_nxt[`SROM_SVC_W-1:0] = service_cond_i;
        end
        `SROM_ADR_STATUS: begin
          rd_nxt[`SROM_STAT_W-1:0] = status_cond_i;
        end
        `SROM_ADR_INT_STAT: begin
          rd_nxt[`SROM_INT_W-1:0] = int_stat_r;
        end
        `SROM_ADR_INT_MASK: begin
          rd_nxt[`SROM_INT_W-1:0] = int_mask_r;
        end
        default: begin
          rd_nxt = 32'h00000000;
        end
      endcase
    end
  end

  // ****************************************
  // per-output configuration
  // ****************************************
  // code and mode bits sit in separate byte lanes so each can be set alone
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (k = 0; k < NUM_OUT; k = k + 1) begin
        cfg_r[k] <= `SROM_CFG_RST;                                  // see RQ11
      end
    end else if (wr && cfg_hit) begin
      if (wb_sel_i[0]) begin
        cfg_r[cfg_idx][`SROM_CODE_W-1:0] <= wb_dat_i[`SROM_CODE_W-1:0];  // see RQ2
      end
      if (wb_sel_i[1]) begin
        cfg_r[cfg_idx][`SROM_CODE_W] <= wb_dat_i[`SROM_CFG_HOLD];        // see RQ2
      end
    end
  end

  // ****************************************
  // manual clear and re-arm
  // ****************************************
  // a clear drops latching for all outputs; only a re-arm write or a reset restores it
  always @(posedge clk_i) begin
    if (rst_i) begin
      clear_r     <= {NUM_OUT{1'b0}};
      armed_r     <= `SROM_ARMED_RST;
      disarm_ev_r <= 1'b0;
    end else begin
      clear_r     <= {NUM_OUT{1'b0}};
      disarm_ev_r <= 1'b0;
      if (wr && (wb_adr_i == `SROM_ADR_CLEAR)) begin
        clear_r <= wb_dat_i[NUM_OUT-1:0] & wmask[NUM_OUT-1:0];      // see RQ3
      end
      if (|clear_r) begin
        armed_r     <= 1'b0;                                        // see RQ4
        disarm_ev_r <= armed_r;
      end else if (wr && (wb_adr_i == `SROM_ADR_CTRL) && wb_sel_i[0] &&
                   wb_dat_i[`SROM_CTRL_REARM]) begin
        armed_r <= 1'b1;                                            // see RQ4
      end
    end
  end

  // ****************************************
  // relay channels
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g = g + 1) begin : chan
      srom_cond_sel u_sel (
        .code_i    (cfg_r[g][`SROM_CODE_W-1:0]),
        .service_i (service_cond_i),
        .status_i  (status_cond_i),
        .cond_o    (cond_w[g])
      );
      srom_relay_chan u_relay (                                     // see RQ1
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .cond_i    (cond_w[g]),
        .hold_i    (cfg_r[g][`SROM_CODE_W]),
        .armed_i   (armed_r),
        .clear_i   (clear_r[g]),
        .relay_o   (relay_o[g]),
        .rise_o    (rise_w[g])
      );
    end
  endgenerate

  // ****************************************
  // interrupts
  // ****************************************
  // new events win over the clear-on-read so none is lost
  always @* begin
    int_stat_nxt = int_stat_r;
    if (rd && (wb_adr_i == `SROM_ADR_INT_STAT)) begin
      int_stat_nxt = {`SROM_INT_W{1'b0}};
    end
    int_stat_nxt[NUM_OUT-1:0]      = int_stat_nxt[NUM_OUT-1:0] | rise_w;
    int_stat_nxt[`SROM_INT_DISARM] = int_stat_nxt[`SROM_INT_DISARM] | disarm_ev_r;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      int_stat_r <= {`SROM_INT_W{1'b0}};
      int_mask_r <= `SROM_MASK_RST;
      irq_o      <= 1'b0;
    end else begin
      int_stat_r <= int_stat_nxt;
      if (wr && (wb_adr_i == `SROM_ADR_INT_MASK)) begin
        int_mask_r <= (int_mask_r & ~wmask) | (wb_dat_i[15:0] & wmask);
      end
      irq_o <= |(int_stat_nxt & int_mask_r);
    end
  end

endmodule // srom_top

// file: inc/srom_defs.vh
// constants of the status relay output mapper: register map, fields, codes
// assumes a 32-bit classic wishbone slave with byte addresses on adr[7:0]
`ifndef SROM_DEFS_VH
`define SROM_DEFS_VH

// ****************************************
// sizes
// ****************************************
`define SROM_NUM_OUT        15
`define SROM_CODE_W         6
`define SROM_SVC_W          27
`define SROM_STAT_W         15
`define SROM_INT_W          16

// ****************************************
// register byte offsets; the config block is given by its adr[7:6] value
// ****************************************
`define SROM_ADR_CTRL       8'h00
`define SROM_ADR_CLEAR      8'h04
`define SROM_ADR_RELAY      8'h08
`define SROM_ADR_SERVICE    8'h0C
`define SROM_ADR_STATUS     8'h10
`define SROM_ADR_INT_STAT   8'h14
`define SROM_ADR_INT_MASK   8'h18
`define SROM_ADR_CFG_BASE   2'b01

// ****************************************
// fields and reset values
// ****************************************
`define SROM_CTRL_REARM     0
`define SROM_CFG_HOLD       8
`define SROM_INT_DISARM     15
`define SROM_CFG_RST        7'h00
`define SROM_MASK_RST       16'h0000
`define SROM_ARMED_RST      1'b1

// ****************************************
// service codes
// ****************************************
`define SROM_SVC_SAMPLE_PRESSURE_FAULT       1
`define SROM_SVC_OXYGEN_SENSOR_TEMP_FAULT    9
`define SROM_SVC_SAMPLE_VALVE_COIL_FAULT     10
`define SROM_SVC_CONVERTER_INPUT_UNDERFLOW   14
`define SROM_SVC_RANGE_ONE_UNCALIBRATED      15
`define SROM_SVC_RANGE_FOUR_UNCALIBRATED     18
`define SROM_SVC_CHAMBER_PRESSURE_FAULT      19
`define SROM_SVC_SPARE_OFF                   23
`define SROM_SVC_GENERAL_ALARM               24
`define SROM_SVC_UNUSED                      25
`define SROM_SVC_CALIBRATION_ALARM           26

// ****************************************
// status group codes start here
// ****************************************
`define SROM_STAT_BASE      6'h20
`define SROM_STAT_AUTO_RANGE 1
`define SROM_STAT_RANGE_ONE 2
`define SROM_STAT_IN_CAL    6
`define SROM_STAT_IN_ZERO   7
`define SROM_STAT_IN_SPAN   8

`endif

// file: verif/srom_relay_sense.sv
// monitoring side: senses the isolated relay contacts
// assumes active high relay drive; a closed contact reads 1
module srom_relay_sense #(
  parameter NUM_OUT = 15
) (
  input  wire  [NUM_OUT-1:0] relay_i,
  output logic [NUM_OUT-1:0] contact_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // no contact bounce modelled, so checks need not debounce
  assign contact_o = relay_i;
endmodule // srom_relay_sense

// file: verif/srom_top_properties.sv
// checker of bus timing and relay causes of the relay output mapper
// assumes it is bound into srom_top: one clock, sync reset
`include "srom_defs.vh"
module srom_top_properties #(
  parameter NUM_OUT = `SROM_NUM_OUT
) (
  input wire                    clk_i,
  input wire                    rst_i,
  input wire                    wb_cyc_i,
  input wire                    wb_stb_i,
  input wire                    wb_we_i,
  input wire [7:0]              wb_adr_i,
  input wire [3:0]              wb_sel_i,
  input wire [31:0]             wb_dat_i,
  input wire [31:0]             wb_dat_o,
  input wire                    wb_ack_o,
  input wire [`SROM_SVC_W-1:0]  service_cond_i,
  input wire [`SROM_STAT_W-1:0] status_cond_i,
  input wire [NUM_OUT-1:0]      relay_o,
  input wire                    irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // helpers
  // ****
  wire      take_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
  reg [5:0] wr_h_r;
  // writes stay in the history long enough to cover the delayed clear
  always @(posedge clk_i) begin
    if (rst_i)
      wr_h_r <= 6'h00;
    else
      wr_h_r <= {wr_h_r[4:0], take_w && wb_we_i};
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****
  // properties
  // ****
  property p_rst_quiet;
    disable iff (1'b0) rst_i |=> relay_o == '0 && !irq_o && !wb_ack_o;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs not idle after reset");
  property p_ack_next;
    take_w |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("no ack one cycle after request");
  property p_ack_drop;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("ack longer than one cycle");
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data outside ack");
  property p_relay_read;
    take_w && !wb_we_i && wb_adr_i == `SROM_ADR_RELAY |=> wb_dat_o == 32'($past(relay_o));
  endproperty
  a_relay_read: assert property (p_relay_read)
    else $error("relay register differs from outputs");
  property p_rise_cause;
    (relay_o & ~$past(relay_o)) != '0 |-> $past(|service_cond_i[26:1] || |status_cond_i);
  endproperty
  a_rise_cause: assert property (p_rise_cause)
    else $error("relay rose with no condition present");
  property p_quiet_stable;
    !take_w && wr_h_r == 6'h00 && $stable(service_cond_i) && $stable(status_cond_i)
      |=> $stable(relay_o);
  endproperty
  a_quiet_stable: assert property (p_quiet_stable)
    else $error("relay changed with no cause");
  property p_irq_cause;
    $rose(irq_o) |-> wr_h_r != 6'h00 || ($past(relay_o, 1) & ~$past(relay_o, 2)) != '0;
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt rose with no event");
endmodule // srom_top_properties

bind srom_top srom_top_properties #(.NUM_OUT(NUM_OUT)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .service_cond_i(service_cond_i),
  .status_cond_i(status_cond_i), .relay_o(relay_o), .irq_o(irq_o));

// file: verif/testbench.sv
// self-checking bench of the relay output mapper
// assumes srom_top with a classic wishbone slave, 40 MHz clock
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h3;
  logic [31:0] wdat = 32'h0, q;
  logic [26:0] svc = 27'h0;
  logic [14:0] stat = 15'h0;
  wire  [31:0] rdat;
  wire         ack, irq;
  wire  [14:0] relay, contact;
  int          err_count = 0, n_compared = 0;
  always #12.5 clk_i = ~clk_i;
  srom_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .service_cond_i(svc), .status_cond_i(stat), .relay_o(relay),
    .irq_o(irq));
  srom_relay_sense u_sense (.relay_i(relay), .contact_o(contact));
  // ****
  // shared tasks
  // ****
  task automatic chk(input string n, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 40);
    q = rdat;
    chk("ack", i < 40, 1);
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    wb(0, a, 0);
    chk(n, q, e);
  endtask
  task automatic pulse;
    svc <= 27'h2;
    repeat (2) @(posedge clk_i);
    svc <= 27'h0;
    repeat (3) @(posedge clk_i);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    rd(8'h40, 0, "cfg0");
    rd(8'h78, 0, "cfg14");
    rd(8'h08, 0, "relay reg");
    rd(8'h00, 1, "armed");
  endtask
  task automatic t_map(input int b, input [26:0] s, input [14:0] st, input [14:0] e);
    for (int n = 0; n < 15; n++)
      wb(1, 8'(8'h40 + 4 * n), 32'(b + n));
    svc <= s;
    stat <= st;
    repeat (2) @(posedge clk_i);
    chk("map", contact, e);
    svc <= 27'h0;
    stat <= 15'h0;
    repeat (2) @(posedge clk_i);
    chk("map off", contact, 0);
  endtask
  task automatic t_hold;
    wb(1, 8'h40, 32'h101);
    pulse;
    chk("held", contact[0], 1);
    wb(1, 8'h04, 1);
    repeat (3) @(posedge clk_i);
    chk("cleared", contact[0], 0);
    rd(8'h00, 0, "disarmed");
    pulse;
    chk("no latch", contact[0], 0);
    wb(1, 8'h00, 1);
    rd(8'h00, 1, "rearmed");
    pulse;
    chk("latched", contact[0], 1);
    wb(1, 8'h04, 1);
    wb(1, 8'h00, 1);
  endtask
  task automatic t_irq;
    sel <= 4'h0;
    wb(1, 8'h18, 32'hFFFF);
    sel <= 4'h3;
    rd(8'h18, 0, "mask sel");
    wb(1, 8'h18, 1);
    wb(0, 8'h14, 0);
    repeat (2) @(posedge clk_i);
    chk("irq idle", irq, 0);
    wb(1, 8'h40, 1);
    pulse;
    chk("irq", irq, 1);
    rd(8'h14, 1, "int stat");
    repeat (2) @(posedge clk_i);
    chk("irq clr", irq, 0);
    rd(8'hFC, 0, "unmapped");
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    t_reset;
    t_map(0, '1, 0, 15'h7FFE);
    t_map(12, '1, 0, 15'h57FF);
    t_map(32, 0, '1, 15'h7FFF);
    t_map(47, '1, '1, 0);
    t_hold;
    t_irq;
    end_of_test;
  end
  // the whole run needs some 290 cycles
  initial begin
    #100us;
    err_count++;
    end_of_test;
  end
endmodule // testbench
